// File: design/fsq_sequencer.sv
`timescale 1ns/1ps
// Contract
// - Status read mode after most commands
// - Locked block refused unless override set
// - Lock-read copies lock bit to status one
// - Lock-read outside block or range: illegal
// - Lock program is 77 then D0
// - Lock program block mismatch: illegal, no write
// - Lock bit set to 1 only by block erase
// - Program clears ready, then suspend-ready set
// - Accepted suspend clears suspend-ready
// - Write pulse finishes before suspending
// - Set program-suspended, then ready
// - Resume clears ready and suspended flag
// - Erase priority lets erase pulse finish
// - User boot: embedded, firmware copy, jump
// - Boot array selected: no flash change
// - Boot array writable only in boot mode
// - Pin low blocks entry bit set
// - Pin low while ready clears entry bit
// - Pin low while busy: command finishes
// - Command against pin protection is error
// - Mode pins disabling flash block all
// - Error flags lock out all but clear
module fsq_sequencer
   import fsq_pkg::*;
#(
   parameter int unsigned P_PROG_WORDS   = fsq_pkg::PROG_WORDS,
   parameter int unsigned P_PROG_PULSES  = fsq_pkg::PROG_PULSES,
   parameter int unsigned P_ERASE_PULSES = fsq_pkg::ERASE_PULSES,
   parameter int unsigned P_LOCK_PULSES  = fsq_pkg::LOCK_PULSES,
   parameter int unsigned P_PULSE_CYC    = fsq_pkg::PULSE_CYC,
   parameter int unsigned P_FW_XFER_CYC  = fsq_pkg::FW_XFER_CYC
) (
   input  wire  logic                core_clk,
   input  wire  logic                rst_n,
   input  wire  fsq_pkg::fsq_wr_t    bus_wr,
   input  wire  logic                rd_valid,
   input  wire  logic [31:0]         rd_addr,
   output logic [15:0]               rd_data,
   input  wire  logic                write_enable_pin,
   input  wire  logic                boot_mode,
   input  wire  logic                user_boot_mode,
   input  wire  logic                flash_disabled,
   input  wire  logic                boot_array_sel,
   input  wire  logic                pe_entry_wr,
   input  wire  logic                pe_entry_wdata,
   input  wire  logic                register_read_select,
   input  wire  logic [7:0]          block_select_reg,
   input  wire  logic                lock_override_bit,
   input  wire  logic                erase_priority_select,
   output logic                      pe_entry_bit,
   output logic                      pin_monitor_reg,
   output fsq_pkg::fsq_stat0_t       status_reg_zero,
   output fsq_pkg::fsq_stat1_t       status_reg_one,
   output logic                      flash_prog_active,
   output logic                      flash_erase_active,
   output logic [3:0]                op_block,
   output fsq_pkg::fsq_boot_t        boot_fetch_sel,
   output logic                      fw_xfer_busy
);
   import fsq_pkg::*;

   localparam int unsigned WCW = $clog2(P_PROG_WORDS + 1);

   function automatic logic in_window(input logic [31:0] a);
      return (a & PE_MASK) == PE_BASE;
   endfunction

   function automatic logic [3:0] blk_of(input logic [31:0] a);
      return a[BLK_LSB +: BLK_W];
   endfunction

   fsq_state_t   state, next_state;
   fsq_op_t      pend, next_pend, op;
   fsq_rmode_t   rmode, next_rmode;
   logic [15:0]  lock_bits;
   logic [3:0]   prog_blk, cmd_blk;
   logic [WCW-1:0] wcnt;
   logic [15:0]  pulse_cnt;
   logic [7:0]   pulses_left;
   logic [15:0]  boot_cnt;
   logic         susp_pend;
   logic         hit, is_byte, cmd_locked, blk_ok, lock_ok;
   logic [7:0]   cmd;
   logic         ev_illegal, ev_eerr, ev_perr, ev_clear;
   logic         ev_start, ev_susp, ev_resume, ev_lockrd;
   logic         pulse_end, op_done, op_abort;

   // -----------------------------------------------------------------
   // Command decode
   // -----------------------------------------------------------------
   // window gate
   assign hit = bus_wr.valid && in_window(bus_wr.addr) && pe_entry_bit
                && !flash_disabled && !fw_xfer_busy;
   assign is_byte    = !bus_wr.word;
   assign cmd        = bus_wr.data[7:0];
   assign cmd_locked = status_reg_zero.illegal | status_reg_zero.erase_err
                       | status_reg_zero.prog_err;
   assign cmd_blk    = (pend == OP_PROG) ? prog_blk : blk_of(bus_wr.addr);
   assign blk_ok     = (block_select_reg <= BLK_SEL_MAX)
                       && (blk_of(bus_wr.addr) == block_select_reg[3:0]);
   assign lock_ok    = lock_bits[cmd_blk] || lock_override_bit;
   assign pulse_end  = pulse_cnt == 16'(P_PULSE_CYC - 1);

   // One decision per bus write; the operation timer runs beside it
   always_comb begin
      next_state = state;
      next_pend  = pend;
      next_rmode = rmode;
      ev_illegal = 1'b0;
      ev_eerr    = 1'b0;
      ev_perr    = 1'b0;
      ev_clear   = 1'b0;
      ev_start   = 1'b0;
      ev_susp    = 1'b0;
      ev_resume  = 1'b0;
      ev_lockrd  = 1'b0;
      op_done    = 1'b0;
      op_abort   = 1'b0;
      if (hit) begin
         next_rmode = RM_STATUS;
         if (cmd_locked) begin
            if (is_byte && cmd == CMD_CLEAR) begin
               ev_clear = 1'b1;
            end else begin
               ev_illegal = 1'b1;
            end
         end else begin
            unique case (state)
               ST_IDLE, ST_SUSPENDED: begin
                  if (!is_byte) begin
                     ev_illegal = 1'b1;
                  end else if (cmd == CMD_NORMAL) begin
                     next_rmode = RM_NORMAL;
                  end else if (cmd == CMD_STATRD || cmd == CMD_CLEAR) begin
                     ev_clear = cmd == CMD_CLEAR;
                  end else if (cmd == CMD_LOCKRD) begin
                     next_pend  = OP_LOCKRD;
                     next_state = ST_CMD2;
                  end else if (cmd == CMD_PROG1 || cmd == CMD_ERASE
                               || cmd == CMD_LOCKPRG) begin
                     if (state == ST_SUSPENDED || !write_enable_pin
                         || (boot_array_sel && !boot_mode)) begin
                        ev_illegal = 1'b1;
                     end else begin
                        next_pend  = (cmd == CMD_PROG1) ? OP_PROG :
                                     (cmd == CMD_ERASE) ? OP_ERASE :
                                     OP_LOCKPRG;
                        next_state = ST_CMD2;
                     end
                  end else if (cmd == CMD_FINAL
                               && state == ST_SUSPENDED) begin
                     ev_resume  = 1'b1;
                     next_state = ST_BUSY;
                  end else begin
                     ev_illegal = 1'b1;
                  end
               end
               ST_CMD2: begin
                  next_state = ST_IDLE;
                  if (pend == OP_PROG) begin
                     if (is_byte && cmd == CMD_PROG2) begin
                        next_state = ST_PDATA;
                     end else begin
                        ev_illegal = 1'b1;
                     end
                  end else if (!(is_byte && cmd == CMD_FINAL) || !blk_ok) begin
                     ev_illegal = 1'b1;
                  end else if (pend == OP_LOCKRD) begin
                     ev_lockrd  = 1'b1;
                     next_rmode = RM_LOCK;
                  end else if (!lock_ok) begin
                     ev_eerr = pend == OP_ERASE;
                     ev_perr = pend == OP_LOCKPRG;
                  end else begin
                     ev_start   = 1'b1;
                     next_state = ST_BUSY;
                  end
               end
               ST_PDATA: begin
                  if (is_byte) begin
                     ev_illegal = 1'b1;
                     next_state = ST_IDLE;
                  end else if (wcnt == WCW'(P_PROG_WORDS - 1)) begin
                     next_state = ST_PFINAL;
                  end
               end
               ST_PFINAL: begin
                  next_state = ST_IDLE;
                  if (!(is_byte && cmd == CMD_FINAL)) begin
                     ev_illegal = 1'b1;
                  end else if (!lock_ok) begin
                     ev_perr = 1'b1;
                  end else begin
                     ev_start   = 1'b1;
                     next_state = ST_BUSY;
                  end
               end
               ST_BUSY, ST_SUSPING: begin
                  // suspend only when ready for it
                  if (state == ST_BUSY && is_byte && cmd == CMD_SUSPEND
                      && status_reg_zero.suspend_ready) begin
                     ev_susp = 1'b1;
                  end else begin
                     ev_illegal = 1'b1;
                  end
               end
               default: next_state = ST_IDLE;
            endcase
         end
      end
      // Operation timer; an error during busy leaves it running
      if (state == ST_BUSY) begin
         // erase without priority abandons the pulse
         if ((susp_pend || ev_susp) && op == OP_ERASE
             && !erase_priority_select) begin
            op_abort   = 1'b1;
            next_state = ST_SUSPING;
         end else if (pulse_end && pulses_left == 8'd1) begin
            op_done    = 1'b1;
            next_state = ST_IDLE;
         end else if (pulse_end && susp_pend) begin
            next_state = ST_SUSPING;
         end
      end else if (state == ST_SUSPING) begin
         next_state = ST_SUSPENDED;
      end
   end

   // -----------------------------------------------------------------
   // Sequencer state
   // -----------------------------------------------------------------
   // Main state, pending command and read mode
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         pend  <= OP_NONE;
         rmode <= RM_STATUS;
      end else begin
         state <= next_state;
         pend  <= next_pend;
         rmode <= next_rmode;
      end
   end

   // Program data counter and target block
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         wcnt     <= '0;
         prog_blk <= '0;
      end else if (hit && state == ST_CMD2) begin
         wcnt <= '0;
      end else if (hit && state == ST_PDATA && !is_byte) begin
         if (wcnt == '0) begin
            prog_blk <= blk_of(bus_wr.addr);
         end
         wcnt <= wcnt + WCW'(1);
      end
   end

   // Running operation, pulse timer and pulses left
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         op          <= OP_NONE;
         op_block    <= '0;
         pulse_cnt   <= '0;
         pulses_left <= '0;
      end else if (ev_start) begin
         op          <= pend;
         op_block    <= cmd_blk;
         pulse_cnt   <= '0;
         pulses_left <= (pend == OP_PROG)  ? 8'(P_PROG_PULSES) :
                        (pend == OP_ERASE) ? 8'(P_ERASE_PULSES) :
                        8'(P_LOCK_PULSES);
      end else if (ev_resume || op_abort) begin
         pulse_cnt <= '0;
      end else if (state == ST_BUSY) begin
         pulse_cnt <= pulse_end ? '0 : pulse_cnt + 16'd1;
         if (pulse_end) begin
            pulses_left <= pulses_left - 8'd1;
         end
      end
   end

   // Suspend request held until the pulse allows it
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         susp_pend <= 1'b0;
      end else if (ev_susp && next_state == ST_BUSY) begin
         susp_pend <= 1'b1;
      end else if (state != ST_BUSY) begin
         susp_pend <= 1'b0;
      end
   end

   // Array drive levels follow the busy state
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         flash_prog_active  <= 1'b0;
         flash_erase_active <= 1'b0;
      end else begin
         flash_prog_active  <= next_state == ST_BUSY && op != OP_ERASE
                               && !ev_start || ev_start && pend != OP_ERASE;
         flash_erase_active <= next_state == ST_BUSY
                               && (ev_start ? pend : op) == OP_ERASE;
      end
   end

   // -----------------------------------------------------------------
   // Status flags
   // -----------------------------------------------------------------
   // Error flags: a new error wins over a clear in the same cycle
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_reg_zero.illegal   <= 1'b0;
         status_reg_zero.erase_err <= 1'b0;
         status_reg_zero.prog_err  <= 1'b0;
      end else begin
         if (ev_illegal || ev_clear) begin
            status_reg_zero.illegal <= ev_illegal;
         end
         if (ev_eerr || ev_clear) begin
            status_reg_zero.erase_err <= ev_eerr;
         end
         if (ev_perr || ev_clear) begin
            status_reg_zero.prog_err <= ev_perr;
         end
      end
   end

   // Ready, suspend-ready and suspended flags
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_reg_zero.ready         <= 1'b1;
         status_reg_zero.suspend_ready <= 1'b0;
         status_reg_zero.erase_susp    <= 1'b0;
         status_reg_zero.prog_susp     <= 1'b0;
      end else begin
         if (ev_start || ev_resume) begin
            status_reg_zero.ready <= 1'b0;
         end else if (op_done || state == ST_SUSPING) begin
            status_reg_zero.ready <= 1'b1;
         end
         status_reg_zero.suspend_ready <= state == ST_BUSY
            && next_state == ST_BUSY && !ev_susp && !susp_pend;
         if (ev_resume) begin
            status_reg_zero.erase_susp <= 1'b0;
            status_reg_zero.prog_susp  <= 1'b0;
         end else if (state == ST_BUSY && next_state == ST_SUSPING) begin
            status_reg_zero.erase_susp <= op == OP_ERASE;
            status_reg_zero.prog_susp  <= op != OP_ERASE;
         end
      end
   end
   assign status_reg_zero.rsvd = 1'b0;
   assign status_reg_one.rsvd  = '0;

   // Lock bits change only when an operation completes
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         lock_bits <= LOCK_INIT;
      end else if (op_done && op == OP_ERASE) begin
         lock_bits[op_block] <= 1'b1;
      end else if (op_done && op == OP_LOCKPRG) begin
         lock_bits[op_block] <= 1'b0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_reg_one.lock_status_flag <= 1'b0;
      end else if (ev_lockrd && register_read_select) begin
         status_reg_one.lock_status_flag <= lock_bits[blk_of(bus_wr.addr)];
      end
   end

   // -----------------------------------------------------------------
   // Pins, entry and reads
   // -----------------------------------------------------------------
   // Entry bit; a busy operation keeps running when the pin drops
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         pe_entry_bit    <= 1'b0;
         pin_monitor_reg <= 1'b0;
      end else begin
         pin_monitor_reg <= write_enable_pin;
         if (!write_enable_pin && status_reg_zero.ready) begin
            pe_entry_bit <= 1'b0;
         end else if (pe_entry_wr
                      && (write_enable_pin || !pe_entry_wdata)) begin
            pe_entry_bit <= pe_entry_wdata;
         end
      end
   end

   // window read returns status or lock
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else if (rd_valid) begin
         if (flash_disabled || !in_window(rd_addr)) begin
            rd_data <= '0;
         end else if (rmode == RM_STATUS) begin
            rd_data <= {8'h00, status_reg_zero};
         end else if (rmode == RM_LOCK) begin
            rd_data <= {15'h0000, lock_bits[blk_of(rd_addr)]};
         end else begin
            rd_data <= '0;
         end
      end
   end

   // boot fetch source; commands wait for the firmware copy
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         boot_fetch_sel <= BF_EMBED;
         fw_xfer_busy   <= 1'b1;
         boot_cnt       <= '0;
      end else if (fw_xfer_busy) begin
         boot_cnt <= boot_cnt + 16'd1;
         if (!user_boot_mode) begin
            boot_fetch_sel <= BF_USER;
            fw_xfer_busy   <= 1'b0;
         end else if (boot_cnt == 16'(P_FW_XFER_CYC - 1)) begin
            boot_fetch_sel <= BF_USERBOOT;
            fw_xfer_busy   <= 1'b0;
         end
      end
   end
endmodule

// File: design/fsq_pkg.sv
package fsq_pkg;
   // Program/erase window and block decode
   localparam logic [31:0] PE_BASE     = 32'h8080_0000;
   localparam logic [31:0] PE_MASK     = 32'hfff0_0000;
   localparam int unsigned BLK_LSB     = 16;
   localparam int unsigned BLK_W       = 4;
   localparam logic [7:0]  BLK_SEL_MAX = 8'h0f;
   localparam logic [15:0] LOCK_INIT   = 16'hffff;
   // Command codes, first byte except CMD_PROG2 and CMD_FINAL
   localparam logic [7:0] CMD_PROG1   = 8'he8;
   localparam logic [7:0] CMD_PROG2   = 8'h80;
   localparam logic [7:0] CMD_FINAL   = 8'hd0;
   localparam logic [7:0] CMD_ERASE   = 8'h20;
   localparam logic [7:0] CMD_LOCKPRG = 8'h77;
   localparam logic [7:0] CMD_LOCKRD  = 8'h71;
   localparam logic [7:0] CMD_STATRD  = 8'h70;
   localparam logic [7:0] CMD_NORMAL  = 8'hff;
   localparam logic [7:0] CMD_SUSPEND = 8'hb0;
   localparam logic [7:0] CMD_CLEAR   = 8'h50;
   // Timing
   localparam int unsigned CLK_MHZ      = 250;
   localparam int unsigned PULSE_NS     = 1000;
   localparam int unsigned PULSE_CYC    = (PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned PROG_WORDS   = 128;
   localparam int unsigned PROG_PULSES  = 4;
   localparam int unsigned ERASE_PULSES = 8;
   localparam int unsigned LOCK_PULSES  = 2;
   localparam int unsigned FW_XFER_CYC  = 64;

   typedef struct packed {
      logic        valid;
      logic        word;
      logic [31:0] addr;
      logic [15:0] data;
   } fsq_wr_t;

   typedef struct packed {
      logic ready;
      logic illegal;
      logic erase_err;
      logic prog_err;
      logic suspend_ready;
      logic erase_susp;
      logic prog_susp;
      logic rsvd;
   } fsq_stat0_t;

   typedef struct packed {
      logic       lock_status_flag;
      logic [6:0] rsvd;
   } fsq_stat1_t;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000, ST_CMD2 = 3'b001, ST_PDATA = 3'b010,
      ST_PFINAL = 3'b011, ST_BUSY = 3'b100, ST_SUSPING = 3'b101,
      ST_SUSPENDED = 3'b110
   } fsq_state_t;

   typedef enum logic [2:0] {
      OP_NONE = 3'b000, OP_PROG = 3'b001, OP_ERASE = 3'b010,
      OP_LOCKPRG = 3'b011, OP_LOCKRD = 3'b100
   } fsq_op_t;

   typedef enum logic [1:0] {
      RM_STATUS = 2'b00, RM_NORMAL = 2'b01, RM_LOCK = 2'b10
   } fsq_rmode_t;

   typedef enum logic [1:0] {
      BF_EMBED = 2'b00, BF_USERBOOT = 2'b01, BF_USER = 2'b10
   } fsq_boot_t;
endpackage

// File: dv/fsq_checker.sv
`timescale 1ns/1ps
module fsq_checker
   import fsq_pkg::*;
(
   input wire logic                core_clk,
   input wire logic                rst_n,
   input wire fsq_pkg::fsq_wr_t    bus_wr,
   input wire logic                rd_valid,
   input wire logic [15:0]         rd_data,
   input wire logic                write_enable_pin,
   input wire logic                flash_disabled,
   input wire logic                pe_entry_wr,
   input wire logic                pe_entry_wdata,
   input wire logic                pe_entry_bit,
   input wire fsq_pkg::fsq_stat0_t status_reg_zero,
   input wire logic                flash_prog_active,
   input wire logic                fw_xfer_busy
);
   logic take, err, b_clr, b_sus, b_fin;
   // Accepted window write; byte codes qualified by it
   assign take = bus_wr.valid && ((bus_wr.addr & PE_MASK) == PE_BASE)
      && pe_entry_bit && !flash_disabled && !fw_xfer_busy;
   assign err = status_reg_zero.illegal | status_reg_zero.erase_err
      | status_reg_zero.prog_err;
   assign b_clr = take && !bus_wr.word && bus_wr.data[7:0] == CMD_CLEAR;
   assign b_sus = take && !bus_wr.word && bus_wr.data[7:0] == CMD_SUSPEND;
   assign b_fin = take && !bus_wr.word && bus_wr.data[7:0] == CMD_FINAL;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   a_entry_blocked: assert property (!write_enable_pin
      && !$past(write_enable_pin) && pe_entry_wr && pe_entry_wdata
      && !pe_entry_bit |=> !pe_entry_bit) else $error("entry set, pin low");
   a_pin_clears: assert property (!write_enable_pin
      && status_reg_zero.ready |=> !pe_entry_bit)
      else $error("entry kept with pin low");
   a_lock_holds: assert property (err && take && !b_clr
      |=> status_reg_zero.illegal) else $error("locked state left");
   a_clear_err: assert property (err && b_clr && !flash_prog_active
      |=> !status_reg_zero.illegal) else $error("clear ignored");
   a_prog_start: assert property ($rose(flash_prog_active)
      |-> !status_reg_zero.ready) else $error("ready high in program");
   a_susp_take: assert property (status_reg_zero.suspend_ready
      && b_sus && !err |=> !status_reg_zero.suspend_ready)
      else $error("suspend ready kept");
   a_susp_ready: assert property ($rose(status_reg_zero.prog_susp)
      |-> !status_reg_zero.ready ##1 status_reg_zero.ready)
      else $error("ready order on suspend");
   a_resume_clr: assert property (status_reg_zero.prog_susp
      && status_reg_zero.ready && b_fin && !err
      |=> !status_reg_zero.ready && !status_reg_zero.prog_susp)
      else $error("resume flags");
   a_read_off: assert property (flash_disabled && rd_valid
      |=> rd_data == 16'h0000) else $error("read while disabled");
endmodule

// File: dv/fsq_cpu_model.sv
`timescale 1ns/1ps
module fsq_cpu_model
   import fsq_pkg::*;
(
   input  wire logic        core_clk,
   output fsq_pkg::fsq_wr_t bus_wr,
   output logic             rd_valid,
   output logic [31:0]      rd_addr,
   input  wire logic [15:0] rd_data
);
   initial begin
      bus_wr = '0;
      rd_valid = 1'b0;
      rd_addr = '0;
   end
   // One write cycle; idle bus shows the inverse, never stale data
   // window writes only
   task automatic wr(input logic w, input logic [31:0] a,
                     input logic [15:0] d);
      @(negedge core_clk);
      bus_wr <= '{valid: 1'b1, word: w, addr: a, data: d};
      @(negedge core_clk);
      bus_wr <= '{valid: 1'b0, word: ~w, addr: ~a, data: ~d};
   endtask
   // Two-cycle command, final byte at an address in the block
   // code then final
   task automatic cmd2(input logic [7:0] c, input logic [31:0] a);
      wr(1'b0, PE_BASE, {8'h00, c});
      wr(1'b0, a, {8'h00, CMD_FINAL});
   endtask
   // Read; data is registered, so it is taken one edge later
   task automatic rd(input logic [31:0] a, output logic [15:0] d);
      @(negedge core_clk);
      rd_valid <= 1'b1;
      rd_addr <= a;
      @(negedge core_clk);
      rd_valid <= 1'b0;
      rd_addr <= ~a;
      d = rd_data;
   endtask
endmodule

// File: dv/fsq_sequencer_tb.sv
`timescale 1ns/1ps
module fsq_sequencer_tb;
   import fsq_pkg::*;
   logic core_clk, rst_n, pin, fdis, ew, ewd, rrs, ovr, rv, pe, pm, pa, ea;
   logic [7:0] bsel;
   logic [15:0] rdd, d;
   logic [31:0] ra;
   logic [3:0] ob;
   fsq_wr_t bus_wr;
   fsq_stat0_t s0;
   fsq_stat1_t s1;
   fsq_boot_t bs;
   logic fb, ba, ep;
   int num_errors = 0;
   int num_checks = 0;
   fsq_sequencer #(.P_PULSE_CYC(4), .P_PROG_WORDS(4), .P_FW_XFER_CYC(3))
      fsq_sequencer_i (.core_clk(core_clk), .rst_n(rst_n), .bus_wr(bus_wr),
      .rd_valid(rv), .rd_addr(ra), .rd_data(rdd), .write_enable_pin(pin),
      .boot_mode(1'b0), .user_boot_mode(1'b0), .flash_disabled(fdis),
      .boot_array_sel(ba), .pe_entry_wr(ew), .pe_entry_wdata(ewd),
      .register_read_select(rrs), .block_select_reg(bsel),
      .lock_override_bit(ovr), .erase_priority_select(ep),
      .pe_entry_bit(pe), .pin_monitor_reg(pm), .status_reg_zero(s0),
      .status_reg_one(s1), .flash_prog_active(pa), .flash_erase_active(ea),
      .op_block(ob), .boot_fetch_sel(bs), .fw_xfer_busy(fb));
   fsq_cpu_model fsq_cpu_model_i (.core_clk(core_clk), .bus_wr(bus_wr),
      .rd_valid(rv), .rd_addr(ra), .rd_data(rdd));
   initial begin
      core_clk = 1'b0;
      forever #2 core_clk = ~core_clk;
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   // Wait on one status bit, bounded
   task automatic wt(input int b);
      repeat (2) @(negedge core_clk);
      for (int i = 0; i < 500 && s0[b] !== 1'b1; i++) @(negedge core_clk);
   endtask
   task automatic lrd(input logic [3:0] b, input logic exp);
      bsel = {4'h0, b};
      fsq_cpu_model_i.cmd2(CMD_LOCKRD, PE_BASE | {12'h000, b, 16'h0000});
      chk(16'(s1.lock_status_flag), 16'(exp));
   endtask
   task automatic end_sim;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge core_clk);
      num_errors++;
      end_sim();
   end
   initial begin
      {pin, fdis, ew, ewd, rrs, ovr, ba, ep} = '0;
      bsel = 8'h00;
      rst_n = 1'b0;
      repeat (6) @(negedge core_clk);
      rst_n = 1'b1;
      repeat (3) @(negedge core_clk);
      chk(16'(fb), 16'h0000);
      chk(16'(bs), 16'(BF_USER));
      {ew, ewd} = 2'b11;
      @(negedge core_clk);
      ew = 1'b0;
      chk(16'({pe, pm}), 16'h0000);
      pin = 1'b1;
      @(negedge core_clk);
      ew = 1'b1;
      @(negedge core_clk);
      ew = 1'b0;
      chk(16'(pe), 16'h0001);
      $display("test entry done");
      bsel = 8'h02;
      fsq_cpu_model_i.cmd2(CMD_LOCKPRG, 32'h8082_0000);
      wt(7);
      fsq_cpu_model_i.rd(PE_BASE, d);
      chk(d, 16'h0080);
      rrs = 1'b1;
      lrd(4'h2, 1'b0);
      fsq_cpu_model_i.rd(32'h8082_0000, d);
      chk(d, 16'h0000);
      fsq_cpu_model_i.cmd2(CMD_LOCKRD, 32'h8085_0000);
      chk(16'(s0.illegal), 16'h0001);
      fsq_cpu_model_i.wr(1'b0, PE_BASE, 16'(CMD_ERASE));
      chk(16'(s0.illegal), 16'h0001);
      fsq_cpu_model_i.wr(1'b0, PE_BASE, 16'(CMD_CLEAR));
      chk(16'(s0), 16'h0080);
      bsel = 8'h10;
      fsq_cpu_model_i.cmd2(CMD_LOCKPRG, PE_BASE);
      chk(16'(s0.illegal), 16'h0001);
      fsq_cpu_model_i.wr(1'b0, PE_BASE, 16'(CMD_CLEAR));
      lrd(4'h0, 1'b1);
      $display("test lock bits done");
      bsel = 8'h02;
      fsq_cpu_model_i.cmd2(CMD_ERASE, 32'h8082_0000);
      chk(16'(s0), 16'h00a0);
      fsq_cpu_model_i.wr(1'b0, PE_BASE, 16'(CMD_CLEAR));
      ovr = 1'b1;
      fsq_cpu_model_i.cmd2(CMD_ERASE, 32'h8082_0000);
      @(negedge core_clk);
      chk(16'({ea, ob}), 16'h0012);
      wt(7);
      ovr = 1'b0;
      lrd(4'h2, 1'b1);
      $display("test erase done");
      bsel = 8'h03;
      fsq_cpu_model_i.wr(1'b0, PE_BASE, 16'(CMD_PROG1));
      fsq_cpu_model_i.wr(1'b0, PE_BASE, 16'(CMD_PROG2));
      for (int i = 0; i < 4; i++)
         fsq_cpu_model_i.wr(1'b1, 32'h8083_0000 + 32'(2 * i), 16'h1230);
      fsq_cpu_model_i.wr(1'b0, PE_BASE, 16'(CMD_FINAL));
      wt(3);
      chk(16'(s0.ready), 16'h0000);
      fsq_cpu_model_i.wr(1'b0, PE_BASE, 16'(CMD_SUSPEND));
      wt(1);
      fsq_cpu_model_i.rd(PE_BASE, d);
      chk(d, 16'h0082);
      fsq_cpu_model_i.wr(1'b0, PE_BASE, 16'(CMD_FINAL));
      chk(16'({s0.ready, s0.prog_susp}), 16'h0000);
      wt(7);
      chk(16'(s0), 16'h0080);
      ep = 1'b1;
      fsq_cpu_model_i.cmd2(CMD_ERASE, 32'h8083_0000);
      fsq_cpu_model_i.wr(1'b0, PE_BASE, 16'(CMD_SUSPEND));
      wt(7);
      chk(16'(s0), 16'h0084);
      fsq_cpu_model_i.wr(1'b0, PE_BASE, 16'(CMD_FINAL));
      wt(7);
      ba = 1'b1;
      fsq_cpu_model_i.wr(1'b0, PE_BASE, 16'(CMD_ERASE));
      chk(16'(s0.illegal), 16'h0001);
      fsq_cpu_model_i.wr(1'b0, PE_BASE, 16'(CMD_CLEAR));
      $display("test suspend done");
      pin = 1'b0;
      repeat (2) @(negedge core_clk);
      chk(16'(pe), 16'h0000);
      fsq_cpu_model_i.wr(1'b0, PE_BASE, 16'(CMD_ERASE));
      chk(16'(s0), 16'h0080);
      fdis = 1'b1;
      fsq_cpu_model_i.rd(PE_BASE, d);
      chk(d, 16'h0000);
      $display("test protection done");
      end_sim();
   end
endmodule
bind fsq_sequencer fsq_checker fsq_checker_i (.core_clk(core_clk),
   .rst_n(rst_n), .bus_wr(bus_wr), .rd_valid(rd_valid), .rd_data(rd_data),
   .write_enable_pin(write_enable_pin), .flash_disabled(flash_disabled),
   .pe_entry_wr(pe_entry_wr), .pe_entry_wdata(pe_entry_wdata),
   .pe_entry_bit(pe_entry_bit), .status_reg_zero(status_reg_zero),
   .flash_prog_active(flash_prog_active), .fw_xfer_busy(fw_xfer_busy));
